// file: logic/focdg_regs.v
// focdg_regs.v: read-only diagnostic register bank of the control engine
// assumes: engine values arrive on clk_sys, the cpu reads by address
// and gets rd_data two cycles after rd_strobe.
//
// Behaviour
// - every diagnostic value is a 16-bit read-only register, reset value undefined unless stated.
// - the three phase currents refresh each pwm cycle from offset-free link current, signed up to 32767.
// - the parking current error is the absolute w-phase difference, unsigned 0 to 4095.
// - phase loss is declared when that difference at parking end exceeds half the expected current.
// - rotor frequency scales by 4 if the quad bit is set, else 2 if the double bit, else 1.
// - the angle-search flag is 1 while searching before torque, 0 when skipped, and resets to 0.
// - the angle-search flag rises at the start of a start command only with catch-spin enabled.
// - the d and q current commands are signed up to 16383 with 4095 as rated current.
// - q-axis torque current feedback is signed with 4095 as rated current.
// - the q-axis modulation is signed -2048 to 2047 with 1430 as full modulation; the symmetric clamp gives -2047 to 2047.
// - the rotor angle is signed with 1024 as 90 degrees.
// - alpha and beta voltages come from bus feedback and modulation, 2355 full depth.
// - the d-axis decoupler output is signed within plus or minus 16383.
`timescale 1ns/1ps
`default_nettype none
`include "focdg_map.vh"
module focdg_regs
(
    // clock, reset, enable
    input wire clk_sys,
    input wire sys_rst,
    input wire clk_en,

    // engine update strobes
    input wire pwm_tick,
    input wire diag_valid,

    // phase current path
    input wire [15:0] link_current,
    input wire [15:0] current_offset,
    input wire [1:0] phase_sel,

    // regulator values
    input wire [15:0] d_cmd_in,
    input wire [15:0] q_cmd_in,
    input wire [15:0] q_fb_in,
    input wire [15:0] q_mod_in,
    input wire [15:0] angle_in,
    input wire [15:0] i_beta_in,
    input wire [15:0] decoupler_in,
    input wire [15:0] v_alpha_in,
    input wire [15:0] v_beta_in,

    // frequency estimate and control bits
    input wire [15:0] freq_raw,
    input wire quad_freq_scale_bit,
    input wire double_freq_scale_bit,
    input wire catch_spin_enable,

    // start sequence
    input wire start_cmd,
    input wire search_done,
    input wire torque_enable,

    // parking
    input wire [15:0] park_expected,
    input wire parking_end,

    // cpu read port
    input wire rd_strobe,
    input wire [15:0] rd_addr,
    output reg [15:0] rd_data,
    output reg rd_valid,
    output reg rd_err,

    // status out
    output reg phase_loss
);
    // engine-side working registers
    reg [15:0] torque_current_feedback;
    reg [15:0] angle_search_flag;
    reg [15:0] rotor_angle_estimate;
    reg [15:0] rotor_frequency_estimate;
    reg [15:0] d_axis_current_command;
    reg [15:0] q_axis_current_command;
    reg [15:0] phase_u_current;
    reg [15:0] phase_v_current;
    reg [15:0] phase_w_current;
    reg [15:0] beta_axis_current;
    reg [15:0] d_axis_decoupler_output;
    reg [15:0] alpha_phase_voltage;
    reg [15:0] beta_phase_voltage;
    reg [15:0] q_axis_modulation;
    reg [15:0] parking_current_error;

    // start edge detector
    reg start_q;
    wire start_edge;

    // read pipeline: address stage, then data stage
    reg [15:0] next_rd_data;
    reg next_hit;
    reg [15:0] rd_addr_q;
    reg rd_pend;

    // combinational helpers of the engine path
    wire [16:0] phase_diff;
    wire [15:0] phase_sat;
    wire [16:0] w_err;
    wire [15:0] w_abs;
    wire [15:0] half_expected;
    wire [15:0] freq_scaled;

    // saturating clamp, signed operand of width 16, negated in a 16 bit sum
    function [15:0] clamp16;
        input [15:0] val;
        input [15:0] lim;
        begin
            if (!val[15] && val > lim)
                clamp16 = lim;
            else if (val[15] && (~val + 16'h0001) > lim)
                clamp16 = ~lim + 16'h0001;
            else
                clamp16 = val;
        end
    endfunction

    // absolute value of a 17 bit signed difference, capped
    function [15:0] abs_cap;
        input [16:0] val;
        input [15:0] lim;
        reg [16:0] mag;
        begin
            mag = val[16] ? (~val + 17'h00001) : val;
            if (mag > {1'b0, lim})
                abs_cap = lim;
            else
                abs_cap = mag[15:0];
        end
    endfunction

    // half of a signed magnitude; the most negative value still fits
    // 16 bits as a magnitude, so no carry is lost before the halving
    function [15:0] half_mag;
        input [15:0] val;
        reg [15:0] mag;
        begin
            mag = val[15] ? (~val + 16'h0001) : val;
            half_mag = {1'b0, mag[15:1]};
        end
    endfunction

    // offset removal from link current sample
    assign phase_diff = {link_current[15], link_current} -
        {current_offset[15], current_offset};
    focdg_sat u_sat
    (
        .din(phase_diff),
        .limit(`FOCDG_PHASE_MAX),
        .dout(phase_sat)
    );

    // w-phase anticipated minus measured
    assign w_err = {park_expected[15], park_expected} -
        {phase_w_current[15], phase_w_current};
    assign w_abs = abs_cap(w_err, `FOCDG_PARK_MAX);

    // loss threshold; compared at 16 bits, both sides unsigned
    assign half_expected = half_mag(park_expected);

    // start_q resets low like the idle start level, so a start held high
    // through reset gives an edge in the first enabled cycle after it
    assign start_edge = start_cmd && !start_q;

    // frequency scaling: quad bit takes priority over double
    assign freq_scaled = quad_freq_scale_bit ? {freq_raw[13:0], 2'b00} :
        (double_freq_scale_bit ? {freq_raw[14:0], 1'b0} :
        freq_raw);

    // engine update path; reset value is a constant as contents are undefined
    // clamps keep each register inside its printed range, so firmware
    // never sees a wrapped sign; the frequency shift is left to wrap,
    // trading range for a cheap scaler
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            torque_current_feedback <= `FOCDG_UNDEF_RST;
            rotor_angle_estimate <= `FOCDG_UNDEF_RST;
            rotor_frequency_estimate <= `FOCDG_UNDEF_RST;
            d_axis_current_command <= `FOCDG_UNDEF_RST;
            q_axis_current_command <= `FOCDG_UNDEF_RST;
            phase_u_current <= `FOCDG_UNDEF_RST;
            phase_v_current <= `FOCDG_UNDEF_RST;
            phase_w_current <= `FOCDG_UNDEF_RST;
            beta_axis_current <= `FOCDG_UNDEF_RST;
            d_axis_decoupler_output <= `FOCDG_UNDEF_RST;
            alpha_phase_voltage <= `FOCDG_UNDEF_RST;
            beta_phase_voltage <= `FOCDG_UNDEF_RST;
            q_axis_modulation <= `FOCDG_UNDEF_RST;
            parking_current_error <= `FOCDG_UNDEF_RST;
        end
        else if (clk_en)
        begin
            // one phase per pwm tick slot, selected by the engine
            if (pwm_tick)
            begin
                case (phase_sel)
                    2'h0: phase_u_current <= phase_sat;
                    2'h1: phase_v_current <= phase_sat;
                    2'h2: phase_w_current <= phase_sat;
                    default: ;
                endcase
            end
            if (diag_valid)
            begin
                d_axis_current_command <= clamp16(d_cmd_in,
                    `FOCDG_CMD_MAX);
                q_axis_current_command <= clamp16(q_cmd_in,
                    `FOCDG_CMD_MAX);
                torque_current_feedback <= clamp16(q_fb_in,
                    `FOCDG_CMD_MAX);
                q_axis_modulation <= clamp16(q_mod_in,
                    `FOCDG_MOD_MAX);
                rotor_angle_estimate <= clamp16(angle_in,
                    `FOCDG_MOD_MAX);
                alpha_phase_voltage <= v_alpha_in;
                beta_phase_voltage <= v_beta_in;
                d_axis_decoupler_output <= clamp16(decoupler_in,
                    `FOCDG_CMD_MAX);
                beta_axis_current <= i_beta_in;
                rotor_frequency_estimate <= freq_scaled;
                parking_current_error <= w_abs;
            end
        end
    end

    // angle search flag: raised on start edge only with catch spin
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            angle_search_flag <= `FOCDG_SEARCH_RST;
            start_q <= 1'b0;
        end
        else if (clk_en)
        begin
            start_q <= start_cmd;
            // the start edge wins over a clear in the same cycle
            if (start_edge && catch_spin_enable)
                angle_search_flag <= 16'h0001;
            else if (start_edge)
                angle_search_flag <= 16'h0000;
            else if (search_done || torque_enable)
                angle_search_flag <= 16'h0000;
        end
    end

    // phase loss at end of parking: error above half the expected
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            phase_loss <= 1'b0;
        else if (clk_en && parking_end)
            phase_loss <= (w_abs > half_expected);
    end

    // address decode of the latched read address
    // unmapped places read as zero with the error flag, so a stray
    // firmware access is visible rather than silently aliased
    always @*
    begin
        next_hit = 1'b1;
        case (rd_addr_q)
            `FOCDG_TORQUE_CURRENT_FEEDBACK:
                next_rd_data = torque_current_feedback;
            `FOCDG_ANGLE_SEARCH_FLAG: next_rd_data = angle_search_flag;
            `FOCDG_ROTOR_ANGLE_ESTIMATE: next_rd_data = rotor_angle_estimate;
            `FOCDG_ROTOR_FREQUENCY_ESTIMATE:
                next_rd_data = rotor_frequency_estimate;
            `FOCDG_D_AXIS_CURRENT_COMMAND:
                next_rd_data = d_axis_current_command;
            `FOCDG_Q_AXIS_CURRENT_COMMAND:
                next_rd_data = q_axis_current_command;
            `FOCDG_PHASE_U_CURRENT: next_rd_data = phase_u_current;
            `FOCDG_PHASE_V_CURRENT: next_rd_data = phase_v_current;
            `FOCDG_PHASE_W_CURRENT: next_rd_data = phase_w_current;
            `FOCDG_BETA_AXIS_CURRENT: next_rd_data = beta_axis_current;
            `FOCDG_D_AXIS_DECOUPLER_OUTPUT:
                next_rd_data = d_axis_decoupler_output;
            `FOCDG_ALPHA_PHASE_VOLTAGE: next_rd_data = alpha_phase_voltage;
            `FOCDG_BETA_PHASE_VOLTAGE: next_rd_data = beta_phase_voltage;
            `FOCDG_Q_AXIS_MODULATION: next_rd_data = q_axis_modulation;
            `FOCDG_PARKING_CURRENT_ERROR:
                next_rd_data = parking_current_error;
            default:
            begin
                next_rd_data = 16'h0000;
                next_hit = 1'b0;
            end
        endcase
    end

    // whole word captured in one edge, so a cpu reading it bytewise
    // later never sees two engine updates mixed
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_addr_q <= 16'h0000;
            rd_pend <= 1'b0;
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
            rd_err <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_pend <= rd_strobe;
            if (rd_strobe)
                rd_addr_q <= rd_addr;
            rd_valid <= rd_pend;
            if (rd_pend)
            begin
                rd_data <= next_rd_data;
                rd_err <= ~next_hit;
            end
        end
    end
endmodule
`default_nettype wire

// file: pkg/focdg_map.vh
// focdg_map.vh: register offsets, value limits and reset values
// assumes: included by the diagnostic register bank files only
`ifndef FOCDG_MAP_VH
`define FOCDG_MAP_VH
// register byte addresses on the microcontroller data bus
`define FOCDG_TORQUE_CURRENT_FEEDBACK 16'h80D6
`define FOCDG_ANGLE_SEARCH_FLAG 16'h8118
`define FOCDG_ROTOR_ANGLE_ESTIMATE 16'h8134
`define FOCDG_ROTOR_FREQUENCY_ESTIMATE 16'h813A
`define FOCDG_D_AXIS_CURRENT_COMMAND 16'h814C
`define FOCDG_Q_AXIS_CURRENT_COMMAND 16'h814E
`define FOCDG_PHASE_U_CURRENT 16'h818A
`define FOCDG_PHASE_V_CURRENT 16'h818C
`define FOCDG_PHASE_W_CURRENT 16'h818E
`define FOCDG_BETA_AXIS_CURRENT 16'h8192
`define FOCDG_D_AXIS_DECOUPLER_OUTPUT 16'h8300
`define FOCDG_ALPHA_PHASE_VOLTAGE 16'h8336
`define FOCDG_BETA_PHASE_VOLTAGE 16'h8338
`define FOCDG_Q_AXIS_MODULATION 16'h83A2
`define FOCDG_PARKING_CURRENT_ERROR 16'h83E4
// value limits
`define FOCDG_PHASE_MAX 16'h7FFF
`define FOCDG_CMD_MAX 16'h3FFF
`define FOCDG_MOD_MAX 16'h07FF
`define FOCDG_PARK_MAX 16'h0FFF
// reset values
`define FOCDG_SEARCH_RST 16'h0000
`define FOCDG_UNDEF_RST 16'h0000
`endif

// file: logic/focdg_sat.v
// focdg_sat.v: symmetric signed saturation of a 17-bit value to 16 bits
// assumes: limit is positive; result stays within plus or minus limit
`timescale 1ns/1ps
`default_nettype none
module focdg_sat
(
    // data in
    input wire [16:0] din,
    input wire [15:0] limit,
    // data out
    output reg [15:0] dout
);
    wire signed [16:0] lim_p;
    wire signed [16:0] lim_n;
    assign lim_p = {1'b0, limit};
    assign lim_n = -{1'b0, limit};
    // clamp both ends so a wrap never flips the sign
    always @*
    begin
        if ($signed(din) > lim_p)
            dout = limit;
        else if ($signed(din) < lim_n)
            dout = lim_n[15:0];
        else
            dout = din[15:0];
    end
endmodule
`default_nettype wire

// file: tb/focdg_regs_checker.sv
// focdg_regs_checker.sv: port assertions of the diagnostic register bank
// assumes: bound to focdg_regs; answers come two edges after the strobe
`timescale 1ns/1ps
`default_nettype none
module focdg_regs_checker
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // read port
    input wire logic clk_en,
    input wire logic rd_strobe,
    input wire logic [15:0] rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_err,
    // parking status
    input wire logic parking_end,
    input wire logic phase_loss
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [15:0] a1;
    logic [15:0] a2;
    // address of the read now answered; no reset, only used with rd_valid
    always @(posedge clk_sys)
    begin
        a1 <= rd_addr;
        a2 <= a1;
    end
    property p_lat; rd_strobe && clk_en ##1 clk_en |=> rd_valid; endproperty
    a_lat: assert property (p_lat) else $error("answer late");
    property p_cause; rd_valid |-> $past(rd_strobe, 2); endproperty
    a_cause: assert property (p_cause) else $error("answer unasked");
    property p_hold;
        !rd_valid |-> $stable(rd_data) && $stable(rd_err);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_flag; rd_valid && a2 == 16'h8118 |-> rd_data <= 1; endproperty
    a_flag: assert property (p_flag) else $error("flag range");
    property p_park;
        rd_valid && a2 == 16'h83E4 |-> rd_data <= 16'h0FFF;
    endproperty
    a_park: assert property (p_park) else $error("park range");
    // offset trick: signed window becomes one unsigned compare
    property p_mod;
        rd_valid && a2 == 16'h83A2 |-> rd_data + 16'h07FF <= 16'h0FFE;
    endproperty
    a_mod: assert property (p_mod) else $error("mod range");
    property p_cmd;
        rd_valid && a2 inside {16'h814C, 16'h814E, 16'h8300}
            |-> rd_data + 16'h3FFF <= 16'h7FFE;
    endproperty
    a_cmd: assert property (p_cmd) else $error("cmd range");
    property p_loss; $changed(phase_loss) |-> $past(parking_end); endproperty
    a_loss: assert property (p_loss) else $error("loss moved");
    c_read: cover property (rd_valid && !rd_err);
    c_err: cover property (rd_valid && rd_err);
    c_loss: cover property ($rose(phase_loss));
endmodule
bind focdg_regs focdg_regs_checker u_chk (.clk_sys, .sys_rst, .clk_en,
    .rd_strobe, .rd_addr, .rd_data, .rd_valid, .rd_err, .parking_end,
    .phase_loss);
`default_nettype wire

// file: tb/focdg_cpu.sv
// focdg_cpu.sv: microcontroller model reading the register bank
// assumes: rd_valid answers within eight edges of the strobe
`timescale 1ns/1ps
`default_nettype none
module focdg_cpu
(
    // clock
    input wire logic clk_sys,
    // read port
    output logic rd_strobe = 1'b0,
    output logic [15:0] rd_addr = 16'h0000,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_err
);
    // address held to the answer edge, then scrambled so no stale match
    task automatic rd(input logic [15:0] a, output logic [15:0] d,
        output logic e, output logic ok);
        int n;
        @(negedge clk_sys);
        rd_strobe = 1'b1;
        rd_addr = a;
        @(negedge clk_sys);
        rd_strobe = 1'b0;
        ok = 1'b0;
        for (n = 0; n < 8 && !ok; n++)
        begin
            @(negedge clk_sys);
            ok = (rd_valid === 1'b1);
        end
        d = rd_data;
        e = rd_err;
        @(negedge clk_sys);
        rd_addr = ~a;
    endtask
endmodule
`default_nettype wire

// file: tb/focdg_regs_bench.sv
// focdg_regs_bench.sv: self-checking bench of the diagnostic register bank
// assumes: focdg_cpu reads; engine inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module focdg_regs_bench;
    logic clk_sys = 1'b0;
    logic clk_en = 1'b1;
    logic sys_rst = 1'b1;
    logic pwm_tick = 1'b0, diag_valid = 1'b0, parking_end = 1'b0;
    logic quad_freq_scale_bit = 1'b0, double_freq_scale_bit = 1'b0;
    logic catch_spin_enable = 1'b0, start_cmd = 1'b0;
    logic search_done = 1'b0, torque_enable = 1'b0;
    logic [1:0] phase_sel = 2'h3;
    logic [15:0] link_current, current_offset, park_expected;
    logic [15:0] d_cmd_in, q_cmd_in, q_fb_in, q_mod_in, angle_in;
    logic [15:0] i_beta_in, decoupler_in, v_alpha_in, v_beta_in, freq_raw;
    wire rd_strobe, rd_valid, rd_err, phase_loss;
    wire [15:0] rd_addr, rd_data;
    int num_errors = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'hD078;
    logic [15:0] ph [3];
    logic [16:0] df;
    logic [15:0] w, pe, x;
    localparam logic [15:0] reg_addr [15] = '{16'h80D6, 16'h8118, 16'h8134,
        16'h813A, 16'h814C, 16'h814E, 16'h818A, 16'h818C, 16'h818E,
        16'h8192, 16'h8300, 16'h8336, 16'h8338, 16'h83A2, 16'h83E4};
    focdg_regs u_dut (.clk_sys, .sys_rst, .clk_en, .pwm_tick,
        .diag_valid, .link_current, .current_offset, .phase_sel, .d_cmd_in,
        .q_cmd_in, .q_fb_in, .q_mod_in, .angle_in, .i_beta_in, .decoupler_in,
        .v_alpha_in, .v_beta_in, .freq_raw, .quad_freq_scale_bit,
        .double_freq_scale_bit, .catch_spin_enable, .start_cmd, .search_done,
        .torque_enable, .park_expected, .parking_end, .rd_strobe, .rd_addr,
        .rd_data, .rd_valid, .rd_err, .phase_loss);
    focdg_cpu u_cpu (.clk_sys, .rd_strobe, .rd_addr, .rd_data, .rd_valid,
        .rd_err);
    // 100 MHz engine clock
    always #5 clk_sys = ~clk_sys;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // symmetric clamp, as the engine saturates
    function automatic logic [15:0] sat(input logic [16:0] v, input [15:0] l);
        if ($signed(v) > $signed({1'b0, l}))
            return l;
        if ($signed(v) < -$signed({1'b0, l}))
            return -l;
        return v[15:0];
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // read one word, 16'h8000 stands for an unmapped place
    task automatic rdc(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic er;
        logic ok;
        u_cpu.rd(a, d, er, ok);
        chk({14'h0, ok, er}, {14'h0, 1'b1, a == 16'h8000});
        chk(d, e);
    endtask
    task automatic pulse(input logic [2:0] m);
        @(negedge clk_sys);
        {parking_end, diag_valid, pwm_tick} = m;
        @(negedge clk_sys);
        {parking_end, diag_valid, pwm_tick} = 3'h0;
    endtask
    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // hang guard, far above the roughly 700 cycles needed
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        end_of_test();
    end
    // main sequence
    initial
    begin
        int i;
        {link_current, current_offset, park_expected} = '0;
        {d_cmd_in, q_cmd_in, q_fb_in, q_mod_in, angle_in, i_beta_in,
            decoupler_in, v_alpha_in, v_beta_in, freq_raw} = '0;
        ph = '{3{16'h0000}};
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        for (i = 0; i < 15; i++)
            rdc(reg_addr[i], 16'h0000);
        rdc(16'h8000, 16'h0000);
        // one phase per tick, selector 3 touches none; first two clamp
        for (i = 0; i < 12; i++)
        begin
            {link_current, current_offset} = rnd();
            if (i < 2)
                {link_current, current_offset} =
                    i ? 32'h80000001 : 32'h7FFF8000;
            phase_sel = i[1:0];
            pulse(3'h1);
            df = $signed(link_current) - $signed(current_offset);
            if (i[1:0] != 2'h3)
                ph[i[1:0]] = sat(df, 16'h7FFF);
            rdc(16'h818A, ph[0]);
            rdc(16'h818C, ph[1]);
            rdc(16'h818E, ph[2]);
        end
        // all four scale-bit settings, extremes first
        for (i = 0; i < 8; i++)
        begin
            {d_cmd_in, q_cmd_in, q_fb_in, q_mod_in, angle_in, i_beta_in,
                decoupler_in, v_alpha_in, v_beta_in, freq_raw} =
                {rnd(), rnd(), rnd(), rnd(), rnd()};
            if (i < 2)
                {d_cmd_in, q_cmd_in, q_fb_in, q_mod_in, angle_in, i_beta_in,
                    decoupler_in, v_alpha_in, v_beta_in, freq_raw} =
                    {10{i ? 16'h7FFF : 16'h8000}};
            {quad_freq_scale_bit, double_freq_scale_bit} = i[1:0];
            pulse(3'h2);
            rdc(16'h814C, sat($signed(d_cmd_in), 16'h3FFF));
            rdc(16'h814E, sat($signed(q_cmd_in), 16'h3FFF));
            rdc(16'h80D6, sat($signed(q_fb_in), 16'h3FFF));
            rdc(16'h83A2, sat($signed(q_mod_in), 16'h07FF));
            rdc(16'h8134, sat($signed(angle_in), 16'h07FF));
            rdc(16'h8300, sat($signed(decoupler_in), 16'h3FFF));
            rdc(16'h8192, i_beta_in);
            rdc(16'h8336, v_alpha_in);
            rdc(16'h8338, v_beta_in);
            rdc(16'h813A, i[1] ? freq_raw << 2 : i[0] ? freq_raw << 1 :
                freq_raw);
        end
        // frozen engine: a load strobe while the enable is low is lost
        x = sat($signed(d_cmd_in), 16'h3FFF);
        d_cmd_in = ~d_cmd_in;
        clk_en = 1'b0;
        pulse(3'h2);
        clk_en = 1'b1;
        rdc(16'h814C, x);
        // parking: exact half is no loss, one count more is a loss
        for (i = 0; i < 6; i++)
        begin
            {w, pe} = rnd();
            w = (i < 2) ? 16'd500 - i : {{4{w[11]}}, w[11:0]};
            pe = (i < 2) ? 16'd1000 : {{4{pe[11]}}, pe[11:0]};
            {link_current, current_offset, phase_sel} = {w, 16'h0000, 2'h2};
            pulse(3'h1);
            park_expected = pe;
            pulse(3'h2);
            pulse(3'h4);
            df = $signed(pe) - $signed(w);
            df = df[16] ? -df : df;
            x = (df > 17'h00FFF) ? 16'h0FFF : df[15:0];
            df = pe[15] ? -{1'b1, pe} : {1'b0, pe};
            rdc(16'h83E4, x);
            chk({15'h0, phase_loss}, {15'h0, x > df[16:1]});
        end
        // start with and without catch-spin, cleared by both causes
        for (i = 0; i < 3; i++)
        begin
            catch_spin_enable = (i != 2);
            @(negedge clk_sys);
            start_cmd = 1'b1;
            rdc(16'h8118, {15'h0, i != 2});
            {search_done, torque_enable} = {i == 0, i == 1};
            rdc(16'h8118, 16'h0000);
            {start_cmd, search_done, torque_enable} = 3'h0;
        end
        // reset in mid-run while the flag is set
        catch_spin_enable = 1'b1;
        @(negedge clk_sys);
        start_cmd = 1'b1;
        @(negedge clk_sys);
        {start_cmd, sys_rst} = 2'h1;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        rdc(16'h8118, 16'h0000);
        rdc(16'h818E, 16'h0000);
        end_of_test();
    end
endmodule
`default_nettype wire
